// [verilog/lvii_top.sv]
// low-voltage indicator input, interrupt flag and axi4-lite options register
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "lvii_map.svh"

// Summary of operation
// - level bit shows the synchronised indicator pin, 1 high and 0 low.
// - low level with enable set raises an interrupt request to the processor.
// - the request carries its own dedicated vector address.
// - a valid indicator interrupt sets the readable flag.
// - flag clears on a written clear bit or on reset.
// - after power-on no interrupt, processor held until pin goes high.
// - no power-down interrupt before the pin is actually seen low.
// - low-to-high pin transition interrupts and wakes the processor.
// - recovery interrupt restarts the clock when the core was stopped.
// - pin is both a plain input and a two-edge interrupt input.
// - with enable, every edge interrupts except first power-on rise; else none.
// - clear bit is write-only, reads zero, writing 1 clears the flag.
module lvii_top (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire logic                por_i,
  input  wire logic                low_supply_indicator_pin_n_i,
  input  wire logic                stopped_i,
  output logic                     irq_o,
  output logic [15:0]              irq_vector_o,
  output logic                     cpu_hold_o,
  output logic                     wake_o,
  output logic                     clk_restart_o,
  input  wire logic [`LVII_AW-1:0] s_axi_awaddr_i,
  input  wire logic                s_axi_awvalid_i,
  output logic                     s_axi_awready_o,
  input  wire logic [`LVII_DW-1:0] s_axi_wdata_i,
  input  wire logic [3:0]          s_axi_wstrb_i,
  input  wire logic                s_axi_wvalid_i,
  output logic                     s_axi_wready_o,
  output logic [1:0]               s_axi_bresp_o,
  output logic                     s_axi_bvalid_o,
  input  wire logic                s_axi_bready_i,
  input  wire logic [`LVII_AW-1:0] s_axi_araddr_i,
  input  wire logic                s_axi_arvalid_i,
  output logic                     s_axi_arready_o,
  output logic [`LVII_DW-1:0]      s_axi_rdata_o,
  output logic [1:0]               s_axi_rresp_o,
  output logic                     s_axi_rvalid_o,
  input  wire logic                s_axi_rready_i
);

  // ==========================================================================
  // how the block hangs together
  // the indicator pin is asynchronous, so it passes two flops before any logic
  // looks at it; the level bit, the edge detector and the power-on tracker all
  // read the second flop only.
  // every pin transition is an event; an enabled event outside power-on sets the
  // flag, and the request to the processor is the flag gated by the enable.
  // power-on is left silently once the pin is seen high, so the first rise after
  // a power-on reset never interrupts when the pin was low during the reset.
  // a set from a new edge wins over a clear written in the same cycle, so an
  // edge arriving during the service routine is never lost.
  // the options register is the only mapped word; other addresses answer with
  // an error response and have no effect.

  // ==========================================================================
  // address decode shared by the write and read paths
  function automatic logic reg_hit(input logic [`LVII_AW-1:0] addr);
    reg_hit = (addr[`LVII_IDX_MSB:`LVII_IDX_LSB] == `LVII_OPT_INDEX);
  endfunction

  // ==========================================================================
  // state
  logic                        pin_meta;
  logic                        pin_sync;
  logic [1:0]                  sync_fill;
  logic                        lvl_prev;
  logic                        irq_en;
  logic                        irq_flag;
  lvii_pkg::lvii_state_type    state;
  logic                        aw_got;
  logic                        w_got;
  logic [`LVII_AW-1:0]         aw_addr;
  logic [`LVII_DW-1:0]         w_data;
  logic [3:0]                  w_strb;

  // ==========================================================================
  // pin synchroniser: only pin_sync is read by logic
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= low_supply_indicator_pin_n_i;
      pin_sync <= pin_meta;
    end
  end

  // ==========================================================================
  // synchroniser fill tracker: pin_sync holds a real pin sample only from the
  // second edge after reset; without this the reset value of the flops would
  // look like a high pin and release the processor too early
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync_fill <= 2'h0;
    end else begin
      sync_fill <= {sync_fill[0], 1'b1};
    end
  end

  // high once pin_sync carries a true sample of the pin
  wire sync_full  = sync_fill[1];

  // ==========================================================================
  // edge detection and power-on tracking
  wire edge_seen  = (pin_sync != lvl_prev);
  wire rise_seen  = edge_seen & pin_sync;
  wire in_por     = (state == lvii_pkg::LVII_ST_POR);
  // only edges outside power-on count, and only when enabled
  wire edge_ev    = edge_seen & ~in_por & irq_en;
  wire wake_ev    = edge_ev & rise_seen;

  // leave power-on once the pin is seen high, without interrupting
  lvii_pkg::lvii_state_type next_state;
  assign next_state = (in_por & (~pin_sync | ~sync_full)) ? lvii_pkg::LVII_ST_POR
                                           : lvii_pkg::LVII_ST_RUN;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state    <= por_i ? lvii_pkg::LVII_ST_POR : lvii_pkg::LVII_ST_RUN;
      lvl_prev <= 1'b1;
    end else begin
      state    <= next_state;
      lvl_prev <= pin_sync;
    end
  end

  // ==========================================================================
  // axi4-lite write channel: address and data in either order
  wire aw_fire   = s_axi_awvalid_i & s_axi_awready_o;
  wire w_fire    = s_axi_wvalid_i & s_axi_wready_o;
  wire have_aw   = aw_got | aw_fire;
  wire have_w    = w_got | w_fire;
  wire wr_do     = have_aw & have_w;
  wire [`LVII_AW-1:0] wr_addr = aw_fire ? s_axi_awaddr_i : aw_addr;
  wire [`LVII_DW-1:0] wr_data = w_fire ? s_axi_wdata_i : w_data;
  wire [3:0]          wr_strb = w_fire ? s_axi_wstrb_i : w_strb;
  wire wr_hit    = reg_hit(wr_addr);
  wire wr_lane   = wr_do & wr_hit & wr_strb[`LVII_BYTE_LANE];
  wire next_bvalid   = wr_do | (s_axi_bvalid_o & ~s_axi_bready_i);
  wire next_aw_got   = have_aw & ~wr_do;
  wire next_w_got    = have_w & ~wr_do;
  wire next_awready  = ~next_aw_got & ~next_bvalid;
  wire next_wready   = ~next_w_got & ~next_bvalid;
  wire [1:0] next_bresp = wr_do ? (wr_hit ? `LVII_RESP_OKAY : `LVII_RESP_SLVERR)
                                : s_axi_bresp_o;

  // register-side effects of a write
  wire clear_wr  = wr_lane & wr_data[`LVII_BIT_CLEAR];
  wire next_en   = wr_lane ? wr_data[`LVII_BIT_EN] : irq_en;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_got          <= 1'b0;
      w_got           <= 1'b0;
      aw_addr         <= '0;
      w_data          <= `LVII_ZERO32;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `LVII_RESP_OKAY;
    end else begin
      aw_got          <= next_aw_got;
      w_got           <= next_w_got;
      aw_addr         <= aw_fire ? s_axi_awaddr_i : aw_addr;
      w_data          <= w_fire ? s_axi_wdata_i : w_data;
      w_strb          <= w_fire ? s_axi_wstrb_i : w_strb;
      s_axi_awready_o <= next_awready;
      s_axi_wready_o  <= next_wready;
      s_axi_bvalid_o  <= next_bvalid;
      s_axi_bresp_o   <= next_bresp;
    end
  end

  // ==========================================================================
  // enable bit and interrupt flag: a new edge wins over a clear
  wire next_flag = edge_ev | (irq_flag & ~clear_wr);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_en   <= 1'b0;
      irq_flag <= 1'b0;
    end else begin
      irq_en   <= next_en;
      irq_flag <= next_flag;
    end
  end

  // ==========================================================================
  // processor-side outputs
  wire next_irq = next_flag & next_en;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_o         <= 1'b0;
      irq_vector_o  <= `LVII_VEC_NONE;
      cpu_hold_o    <= 1'b1;
      wake_o        <= 1'b0;
      clk_restart_o <= 1'b0;
    end else begin
      irq_o         <= next_irq;
      irq_vector_o  <= next_irq ? `LVII_VEC_ADDR : `LVII_VEC_NONE;
      cpu_hold_o    <= (next_state == lvii_pkg::LVII_ST_POR);
      wake_o        <= wake_ev;
      clk_restart_o <= wake_ev & stopped_i;
    end
  end

  // ==========================================================================
  // axi4-lite read channel
  wire ar_fire     = s_axi_arvalid_i & s_axi_arready_o;
  wire rd_hit      = reg_hit(s_axi_araddr_i);
  wire next_rvalid = ar_fire | (s_axi_rvalid_o & ~s_axi_rready_i);
  wire next_arready = ~next_rvalid;
  // clear bit and mask-option bits always read as zero
  logic [7:0] opt_rd;
  always_comb begin
    opt_rd                  = `LVII_ZERO8;
    opt_rd[`LVII_BIT_FLAG]  = irq_flag;
    opt_rd[`LVII_BIT_LEVEL] = pin_sync;
    opt_rd[`LVII_BIT_EN]    = irq_en;
  end
  wire [`LVII_DW-1:0] next_rdata = !ar_fire ? s_axi_rdata_o
                                 : rd_hit ? {24'h00_0000, opt_rd} : `LVII_ZERO32;
  wire [1:0] next_rresp = !ar_fire ? s_axi_rresp_o
                        : rd_hit ? `LVII_RESP_OKAY : `LVII_RESP_SLVERR;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= `LVII_ZERO32;
      s_axi_rresp_o   <= `LVII_RESP_OKAY;
    end else begin
      s_axi_arready_o <= next_arready;
      s_axi_rvalid_o  <= next_rvalid;
      s_axi_rdata_o   <= next_rdata;
      s_axi_rresp_o   <= next_rresp;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  level_read_a: assert property (ar_fire && rd_hit |=>
      s_axi_rdata_o[`LVII_BIT_LEVEL] == $past(pin_sync))
    else $error("level bit does not follow the pin");

  low_request_a: assert property (edge_ev && !pin_sync && !wr_lane
      |=> irq_o)
    else $error("low level with enable gave no request");

  vector_a: assert property (irq_o |-> irq_vector_o == `LVII_VEC_ADDR)
    else $error("request without its dedicated vector");

  flag_set_a: assert property (edge_ev |=> irq_flag ##1 (irq_flag || $past(clear_wr)))
    else $error("edge did not set the flag");

  flag_clear_a: assert property (clear_wr && !edge_ev |=> !irq_flag && !irq_o)
    else $error("clear bit did not clear the flag");

  // a clear written in the same cycle as a new edge must not lose the edge
  set_wins_a: assert property (edge_ev && clear_wr |=> irq_flag)
    else $error("clear beat a simultaneous edge");

  // the flag stays set until software clears it
  flag_stays_a: assert property (irq_flag && !clear_wr |=> irq_flag)
    else $error("flag dropped without a clear");

  clear_reads_a: assert property (s_axi_rvalid_o |-> !s_axi_rdata_o[`LVII_BIT_CLEAR])
    else $error("clear bit read back nonzero");

  por_hold_a: assert property (in_por && !pin_sync |=> cpu_hold_o && !irq_flag)
    else $error("power-on without hold or with a flag");

  edge_cause_a: assert property ($rose(irq_flag) |->
      $past(pin_sync) != $past(lvl_prev) && $past(state) == lvii_pkg::LVII_ST_RUN)
    else $error("flag rose without a pin edge in run state");

  wake_a: assert property (edge_ev && pin_sync |=> wake_o && irq_flag)
    else $error("rising edge did not wake");

  // wake is a single-cycle pulse per rising edge event
  wake_pulse_a: assert property (wake_o && !wake_ev |=> !wake_o)
    else $error("wake pulse stretched");

  // once the pin is truly seen high, power-on ends and the processor runs
  hold_release_a: assert property (in_por && pin_sync && sync_full |=> !cpu_hold_o)
    else $error("processor held with the pin high");

  restart_a: assert property (wake_ev && stopped_i |=> clk_restart_o)
    else $error("stopped clock not restarted");

  enable_off_a: assert property (!irq_en |=> !$rose(irq_flag))
    else $error("flag set while disabled");

  request_a: assert property (irq_o == (irq_flag && irq_en))
    else $error("request does not match flag and enable");

  // a write to the low lane updates the enable bit
  enable_write_a: assert property (wr_lane |=> irq_en == $past(wr_data[`LVII_BIT_EN]))
    else $error("enable bit did not take the written value");

  // bus answers: response one cycle after both halves are in
  write_resp_a: assert property (wr_do |=> s_axi_bvalid_o)
    else $error("write response missing");

  read_resp_a: assert property (ar_fire |=> s_axi_rvalid_o)
    else $error("read response missing");

  // a pending write response waits for the master
  bvalid_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response withdrawn");

  cover_fall_c:  cover property (edge_ev && !pin_sync ##1 irq_o);
  cover_rise_c:  cover property (wake_ev && stopped_i ##1 clk_restart_o);
  cover_clear_c: cover property (irq_flag ##1 clear_wr ##1 !irq_flag);
  cover_por_c:   cover property (in_por ##1 !in_por);
  cover_both_c:  cover property (edge_ev && clear_wr ##1 irq_flag);

endmodule

// [verilog/lvii_map.svh]
// register map, field positions and fixed codes of the low-voltage indicator block
`ifndef LVII_MAP_SVH
`define LVII_MAP_SVH

// ==========================================================================
// bus geometry
`define LVII_AW          8
`define LVII_DW          32
`define LVII_IDX_LSB     2
`define LVII_IDX_MSB     7

// ==========================================================================
// options register: index, byte address is four times the index
`define LVII_OPT_INDEX   6'h0f

// ==========================================================================
// options register fields
`define LVII_BIT_FLAG    7
`define LVII_BIT_LEVEL   6
`define LVII_BIT_CLEAR   5
`define LVII_BIT_EN      4
`define LVII_BYTE_LANE   0

// ==========================================================================
// dedicated vector and bus answers
`define LVII_VEC_ADDR    16'h1ff6
`define LVII_VEC_NONE    16'h0000
`define LVII_RESP_OKAY   2'h0
`define LVII_RESP_SLVERR 2'h2
`define LVII_ZERO32      32'h0000_0000
`define LVII_ZERO8       8'h00

`endif

// [verilog/lvii_pkg.sv]
// types shared by the low-voltage indicator block
package lvii_pkg;

  // ==========================================================================
  // tracking states, one-hot
  typedef enum logic [1:0] {
    LVII_ST_POR = 2'b01,  // power-on: cpu held, first rise ignored
    LVII_ST_RUN = 2'b10   // normal: every edge may interrupt
  } lvii_state_type;

endpackage

// [tb/lvii_detector.sv]
// behavioural supply detector that drives the low-supply indicator pin
`timescale 1ns/1ps

module lvii_detector (
  input  wire logic clk_i,
  input  wire logic supply_ok_i,
  input  wire logic power_on_i,
  output logic      pin_n_o
);
  // ==========================================================================
  // pin follows the supply verdict, forced high while power comes up
  always_ff @(posedge clk_i) begin
    pin_n_o <= power_on_i ? 1'b1 : supply_ok_i;
  end
endmodule

// [tb/lvii_top_test.sv]
// self-checking bench for the low-voltage indicator block
`timescale 1ns/1ps
`include "lvii_map.svh"

module lvii_top_test;
  typedef struct {logic [1:0] op; logic [7:0] val; logic stp; logic irq;
                  logic [7:0] rd; int wk; int rs;} lvii_row_type;
  logic        clk_i = 0, srst_i = 1, por_i = 1, stopped_i = 0, supply_ok = 1, power_on = 1;
  logic        pin_n, irq, hold, wake, restart, awready, wready, bvalid, arready, rvalid;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0]  wstrb = 0;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] vec;
  int          error_cnt = 0, comparisons = 0, wake_cnt = 0, rest_cnt = 0, w0, r0;
  lvii_row_type rows [13] = '{'{1,8'h10,0,0,8'h50,0,0}, '{0,0,0,1,8'h90,0,0},
    '{1,8'h30,0,0,8'h10,0,0}, '{0,1,1,1,8'hd0,1,1}, '{1,8'h00,1,0,8'hc0,0,0},
    '{1,8'h20,0,0,8'h40,0,0}, '{0,0,0,0,8'h00,0,0}, '{0,1,0,0,8'h40,0,0},
    '{2,8'h10,0,0,8'h40,0,0}, '{1,8'h10,0,0,8'h50,0,0}, '{0,0,0,1,8'h90,0,0},
    '{1,8'h30,0,0,8'h10,0,0}, '{0,1,0,1,8'hd0,1,0}};

  // ==========================================================================
  // clock, partner and design
  always #2.5 clk_i = ~clk_i;
  lvii_detector u_lvii_detector (.clk_i(clk_i), .supply_ok_i(supply_ok),
    .power_on_i(power_on), .pin_n_o(pin_n));
  lvii_top u_lvii_top (.clk_i(clk_i), .srst_i(srst_i), .por_i(por_i),
    .low_supply_indicator_pin_n_i(pin_n), .stopped_i(stopped_i), .irq_o(irq),
    .irq_vector_o(vec), .cpu_hold_o(hold), .wake_o(wake), .clk_restart_o(restart),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

  // counts one-cycle pulses on the wake and restart outputs
  always @(negedge clk_i) begin
    if (wake === 1'b1) wake_cnt++;
    if (restart === 1'b1) rest_cnt++;
  end

  // ==========================================================================
  // comparison, verdict and watchdog
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(20000 * 5);
    error_cnt++;
    print_verdict();
  end

  // ==========================================================================
  // axi4-lite master tasks, handshakes judged just before each rising edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    bit at, wt, bt;
    n = 0;
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(negedge clk_i);
      at = awvalid & awready; wt = wvalid & wready; bt = bvalid; resp = bresp;
      @(posedge clk_i);
      if (at) awvalid <= 0;
      if (wt) wvalid <= 0;
      n++;
    end while (!bt && n < 50);
    bready <= 0;
    if (!bt) check(32'h0000_0bad, 32'h0000_0000);
  endtask

  task automatic axi_read(input logic [7:0] a);
    int n;
    bit at, rt;
    n = 0;
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(negedge clk_i);
      at = arvalid & arready; rt = rvalid; rd = rdata; resp = rresp;
      @(posedge clk_i);
      if (at) arvalid <= 0;
      n++;
    end while (!rt && n < 50);
    rready <= 0;
    if (!rt) check(32'h0000_0bad, 32'h0000_0000);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    check(hold, 1'b1);
    srst_i <= 0;
    power_on <= 0;
    repeat (8) @(posedge clk_i);
    check(hold, 1'b0);
    check(irq, 1'b0);
    axi_read(8'h3c);
    check(rd, 32'h0000_0040);
    $display("test power_on done");
    foreach (rows[i]) begin
      w0 = wake_cnt;
      r0 = rest_cnt;
      stopped_i <= rows[i].stp;
      if (rows[i].op == 0) supply_ok <= rows[i].val[0];
      else axi_write(8'h3c, {24'h00_0000, rows[i].val}, rows[i].op == 1 ? 4'h1 : 4'h0);
      repeat (8) @(posedge clk_i);
      check(irq, rows[i].irq);
      check(vec, rows[i].irq ? `LVII_VEC_ADDR : `LVII_VEC_NONE);
      check(wake_cnt - w0, rows[i].wk);
      check(rest_cnt - r0, rows[i].rs);
      axi_read(8'h3c);
      check(rd, {24'h00_0000, rows[i].rd});
      $display("test row %0d done", i);
    end
    axi_read(8'h00);
    check(resp, `LVII_RESP_SLVERR);
    check(rd, 32'h0000_0000);
    axi_write(8'h04, 32'h0000_00ff, 4'hf);
    check(resp, `LVII_RESP_SLVERR);
    $display("test unmapped done");
    srst_i <= 1;
    por_i <= 0;
    repeat (2) @(posedge clk_i);
    srst_i <= 0;
    repeat (3) @(posedge clk_i);
    check(hold, 1'b0);
    check(irq, 1'b0);
    axi_read(8'h3c);
    check(rd, 32'h0000_0040);
    $display("test second reset done");
    supply_ok <= 0;
    srst_i <= 1;
    por_i <= 1;
    repeat (4) @(posedge clk_i);
    srst_i <= 0;
    repeat (8) @(posedge clk_i);
    check(hold, 1'b1);
    axi_write(8'h3c, 32'h0000_0010, 4'h1);
    repeat (4) @(posedge clk_i);
    check(irq, 1'b0);
    w0 = wake_cnt;
    supply_ok <= 1;
    repeat (8) @(posedge clk_i);
    check(hold, 1'b0);
    check(irq, 1'b0);
    check(wake_cnt - w0, 0);
    axi_read(8'h3c);
    check(rd, 32'h0000_0050);
    $display("test power-on low pin done");
    print_verdict();
  end
endmodule
